// file: rtl/optical_module_mgmt_serial.sv
// Management side of a pluggable optical module: two-wire serial target with an
// identification page and a diagnostics page, monitors, flags and a Wishbone register file.
// Assumes MCLK at 200 MHz, pins asynchronous to it, monitor inputs on MCLK.
`timescale 1ns/1ps
`include "mgmt_defines.svh"

// Contract
// [R1] Answer serial address 0x50 and serve a 256-byte identification page.
// [R2] Answer serial address 0x51 for diagnostics; identification page stays unchanged.
// [R3] The host makes the serial clock; the module never drives it.
// [R4] Sample write data on the rising serial clock; store only to unprotected bytes.
// [R5] Change the driven data bit on the falling serial clock when reading.
// [R6] Start and stop conditions from the host frame every transaction.
// [R7] Byte-wide memory, addressed singly or sequentially with auto increment.
// [R8] Light-absent output is 1 with no optical signal, 0 in normal reception.
// [R9] Laser output goes off within 10 us of shutdown being asserted.
// [R10] Received data outputs are enabled while light-absent is low.
// [R11] Temperature, bias, transmit power, receive power and supply readable live.
// [R12] Alarm and warning flags set when a monitor leaves its configured range.
// [R13] Reported values are calibrated internally by default.
// [R14] Laser off while shutdown is high or open, on while it is low; a laser fault or the soft-disable control bit also turns it off.
// [R15] Fault output high for a laser fault, low in normal operation.
// [R16] The presence pin is held at ground.
// [R17] Writes to protected bytes are acknowledged but leave contents unchanged.
// [R18] Multi-byte diagnostic reads return values from one coherent snapshot; only the monitor words are snapshotted, flag bytes are read live.
module optical_module_mgmt_serial #(
  parameter int MON_W = 16
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE,
  output logic PRESENCE_PIN_OUT,
  output logic PRESENCE_PIN_OE,
  input wire logic TX_DISABLE_PIN,
  input wire logic LASER_FAULT_IN,
  input wire logic SIGNAL_DETECT_IN,
  input wire logic MEAS_VALID,
  input wire logic [MON_W-1:0] MEAS_TEMP,
  input wire logic [MON_W-1:0] MEAS_VCC,
  input wire logic [MON_W-1:0] MEAS_BIAS,
  input wire logic [MON_W-1:0] MEAS_TX_POWER,
  input wire logic [MON_W-1:0] MEAS_RX_POWER,
  output logic LASER_ON,
  output logic TX_FAULT,
  output logic RX_LIGHT_ABSENT,
  output logic RX_DATA_EN
);
  logic [7:0] mem [0:(1<<`MEM_ADDR_W)-1];
  logic [`CTRL_W-1:0] ctrl;
  logic [`EV_W-1:0] status;
  logic [`EV_W-1:0] mask;
  logic [`MEM_ADDR_W-1:0] mem_addr;
  logic [MON_W-1:0] slope [0:`NUM_MON-1];
  logic [MON_W-1:0] offset [0:`NUM_MON-1];
  logic [MON_W-1:0] cal [0:`NUM_MON-1];
  logic [MON_W-1:0] snap [0:`NUM_MON-1];
  logic [2*`NUM_MON-1:0] alarm;
  logic [2*`NUM_MON-1:0] warn;
  logic [1:0] dis_s;
  logic [1:0] fault_s;
  logic [1:0] sd_s;
  logic sd_prev;

  wire sda_oe;
  wire dev_sel;
  wire [7:0] ptr;
  wire [7:0] rd_data;
  wire wr_stb;
  wire [7:0] wr_data;
  wire start_stb;

  // The host alone drives the serial clock; it is only ever an input here.
  i2c_target_core i2c_target_core_inst ( // [R3]
    .clk(MCLK),
    .srst(SRST),
    .ce(CE),
    .scl_pin(SERIAL_CLOCK_PIN),
    .sda_pin(SERIAL_DATA_PIN_IN),
    .sda_oe(sda_oe),
    .dev_sel(dev_sel),
    .ptr(ptr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .start_stb(start_stb)
  );

  assign SERIAL_DATA_PIN_OE = sda_oe;

  wire [MON_W-1:0] raw [0:`NUM_MON-1];
  assign raw[0] = MEAS_TEMP;
  assign raw[1] = MEAS_VCC;
  assign raw[2] = MEAS_BIAS;
  assign raw[3] = MEAS_TX_POWER;
  assign raw[4] = MEAS_RX_POWER;

  // Calibration: value = raw * slope / 256 + offset, slope defaults to unity.
  wire [MON_W-1:0] cal_next [0:`NUM_MON-1];
  wire [2*`NUM_MON-1:0] alarm_next;
  wire [2*`NUM_MON-1:0] warn_next;
  genvar g;
  generate
    for (g = 0; g < `NUM_MON; g++)
    begin : mon
      localparam int TB = (1 << (`MEM_ADDR_W - 1)) + g * `THR_STRIDE;
      wire [2*MON_W-1:0] prod = raw[g] * slope[g];
      wire [MON_W-1:0] ah = {mem[TB+`THR_AH], mem[TB+`THR_AH+1]};
      wire [MON_W-1:0] al = {mem[TB+`THR_AL], mem[TB+`THR_AL+1]};
      wire [MON_W-1:0] wh = {mem[TB+`THR_WH], mem[TB+`THR_WH+1]};
      wire [MON_W-1:0] wl = {mem[TB+`THR_WL], mem[TB+`THR_WL+1]};
      assign cal_next[g] = prod[`CAL_MSB:`CAL_LSB] + offset[g]; // [R13]
      assign alarm_next[2*g+1] = cal[g] > ah; // [R12]
      assign alarm_next[2*g] = cal[g] < al; // [R12]
      assign warn_next[2*g+1] = cal[g] > wh; // [R12]
      assign warn_next[2*g] = cal[g] < wl; // [R12]
    end
  endgenerate

  // Serial read path: live bytes come from the snapshot taken at each start.
  wire [7:0] live_off = ptr - `LIVE_BASE;
  wire in_live = dev_sel && ptr >= `LIVE_BASE && ptr < `LIVE_END;
  wire [MON_W-1:0] live_word = snap[live_off[3:1]];
  wire [7:0] live_byte = live_off[0] ? live_word[7:0] : live_word[15:8];
  wire [7:0] flag_byte =
    (ptr == `ALARM_BYTE_HI) ? {6'h00, alarm[9:8]} :
    (ptr == `ALARM_BYTE_LO) ? alarm[7:0] :
    (ptr == `WARN_BYTE_HI) ? {6'h00, warn[9:8]} :
    (ptr == `WARN_BYTE_LO) ? warn[7:0] : 8'h00;
  wire in_flags = dev_sel && ptr >= `LIVE_END && ptr < `PROT_END;
  assign rd_data = in_live ? live_byte : in_flags ? flag_byte : mem[{dev_sel, ptr}]; // [R11]

  // Write protection per segment; the monitor area never takes serial writes.
  wire prot_id = (dev_sel == `PAGE_ID) && ctrl[`CTRL_ID_WP];
  wire prot_thr = (dev_sel == `PAGE_DIAG) && ptr < `THR_END && ctrl[`CTRL_THR_WP];
  wire prot_live = (dev_sel == `PAGE_DIAG) && ptr >= `LIVE_BASE && ptr < `PROT_END;
  wire host_write = wr_stb && !(prot_id || prot_thr || prot_live); // [R4] [R17]

  // Register bus decode.
  wire bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire [7:0] adr = {WB_ADR_I[7:2], 2'b00};
  wire [31:0] lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}},
                           {8{WB_SEL_I[0]}}};
  wire wr_req = bus_req && WB_WE_I;
  wire rd_req = bus_req && !WB_WE_I;
  wire hit_ctrl = adr == `REG_CTRL;
  wire hit_status = adr == `REG_STATUS;
  wire hit_mask = adr == `REG_MASK;
  wire hit_live = adr == `REG_LIVE;
  wire hit_maddr = adr == `REG_MEM_ADDR;
  wire hit_mdata = adr == `REG_MEM_DATA;
  wire hit_flags = adr == `REG_FLAGS;
  wire [`NUM_MON-1:0] hit_slope;
  wire [`NUM_MON-1:0] hit_offset;
  wire [31:0] slope_rd [0:`NUM_MON];
  wire [31:0] offset_rd [0:`NUM_MON];
  assign slope_rd[0] = 32'h0000_0000;
  assign offset_rd[0] = 32'h0000_0000;
  generate
    for (g = 0; g < `NUM_MON; g++)
    begin : dec
      assign hit_slope[g] = adr == `REG_SLOPE_BASE + 8'(g) * `REG_STRIDE;
      assign hit_offset[g] = adr == `REG_OFFSET_BASE + 8'(g) * `REG_STRIDE;
      assign slope_rd[g+1] = slope_rd[g] | (hit_slope[g] ? {16'h0000, slope[g]} : 32'h0);
      assign offset_rd[g+1] = offset_rd[g] | (hit_offset[g] ? {16'h0000, offset[g]} : 32'h0);
    end
  endgenerate

  wire [31:0] ctrl_wr = ({29'h0, ctrl} & ~lane_mask) | (WB_DAT_I & lane_mask);
  wire [31:0] mask_wr = ({27'h0, mask} & ~lane_mask) | (WB_DAT_I & lane_mask);
  wire [31:0] maddr_wr = ({23'h0, mem_addr} & ~lane_mask) | (WB_DAT_I & lane_mask);
  wire [31:0] live_word_rd = {28'h0, TX_FAULT, RX_LIGHT_ABSENT, LASER_ON, dis_s[1]};
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl} :
    hit_status ? {27'h0, status} :
    hit_mask ? {27'h0, mask} :
    hit_live ? live_word_rd :
    hit_maddr ? {23'h0, mem_addr} :
    hit_mdata ? {24'h0, mem[mem_addr]} :
    hit_flags ? {6'h00, warn, 6'h00, alarm} :
    slope_rd[`NUM_MON] | offset_rd[`NUM_MON];

  // Events for the interrupt status register.
  wire [`EV_W-1:0] events;
  assign events[`EV_ALARM] = |(alarm_next & ~alarm);
  assign events[`EV_WARN] = |(warn_next & ~warn);
  assign events[`EV_FAULT] = fault_s[1] & ~TX_FAULT;
  assign events[`EV_LIGHT] = sd_s[1] ^ sd_prev;
  assign events[`EV_HOST_WR] = host_write;
  wire clr_status = rd_req && hit_status;
  wire [`EV_W-1:0] next_status = (status & ~{`EV_W{clr_status}}) | events;
  wire laser_kill = dis_s[1] | ctrl[`CTRL_SOFT_DIS] | fault_s[1];

  // Pin synchronisers; an open shutdown pin reads high through the board pull-up.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      dis_s <= 2'h3;
      fault_s <= 2'h0;
      sd_s <= 2'h0;
    end
    else if (CE)
    begin
      dis_s <= {dis_s[0], TX_DISABLE_PIN};
      fault_s <= {fault_s[0], LASER_FAULT_IN};
      sd_s <= {sd_s[0], SIGNAL_DETECT_IN};
    end
  end

  // Status pins and laser control; the shutdown path is a few cycles, far below 10 us.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      LASER_ON <= 1'b0;
      TX_FAULT <= 1'b0;
      RX_LIGHT_ABSENT <= 1'b1;
      RX_DATA_EN <= 1'b0;
      PRESENCE_PIN_OUT <= 1'b0;
      PRESENCE_PIN_OE <= 1'b1;
      SERIAL_DATA_PIN_OUT <= 1'b0;
      sd_prev <= 1'b0;
    end
    else if (CE)
    begin
      LASER_ON <= ~laser_kill; // [R9] [R14]
      TX_FAULT <= fault_s[1]; // [R15]
      RX_LIGHT_ABSENT <= ~sd_s[1]; // [R8]
      RX_DATA_EN <= sd_s[1]; // [R10]
      PRESENCE_PIN_OUT <= 1'b0; // [R16]
      PRESENCE_PIN_OE <= 1'b1; // [R16]
      SERIAL_DATA_PIN_OUT <= 1'b0;
      sd_prev <= sd_s[1];
    end
  end

  // Monitor values, flags and the per-transaction snapshot.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      alarm <= '0;
      warn <= '0;
      for (int i = 0; i < `NUM_MON; i++)
      begin
        cal[i] <= '0;
        snap[i] <= '0;
      end
    end
    else if (CE)
    begin
      alarm <= alarm_next; // [R12]
      warn <= warn_next; // [R12]
      for (int i = 0; i < `NUM_MON; i++)
      begin
        if (MEAS_VALID)
          cal[i] <= cal_next[i]; // [R11] [R13]
        if (start_stb)
          snap[i] <= cal[i]; // [R18]
      end
    end
  end

  // Byte memory for both pages; the bus write wins over a serial write in the same cycle.
  always_ff @(posedge MCLK)
  begin
    if (CE)
    begin
      if (host_write)
        mem[{dev_sel, ptr}] <= wr_data; // [R4] [R7]
      if (wr_req && hit_mdata && WB_SEL_I[0])
        mem[mem_addr] <= WB_DAT_I[7:0];
    end
  end

  // Wishbone slave: one-cycle answer, unmapped reads return zero.
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      ctrl <= `CTRL_RESET;
      status <= '0;
      mask <= '0;
      mem_addr <= '0;
      IRQ <= 1'b0;
      for (int i = 0; i < `NUM_MON; i++)
      begin
        slope[i] <= `SLOPE_RESET;
        offset[i] <= `OFFSET_RESET;
      end
    end
    else if (CE)
    begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= rd_req ? rd_mux : 32'h0000_0000;
      status <= next_status;
      IRQ <= |(next_status & mask);
      if (wr_req && hit_ctrl)
        ctrl <= ctrl_wr[`CTRL_W-1:0];
      if (wr_req && hit_mask)
        mask <= mask_wr[`EV_W-1:0];
      if (wr_req && hit_maddr)
        mem_addr <= maddr_wr[`MEM_ADDR_W-1:0];
      for (int i = 0; i < `NUM_MON; i++)
      begin
        if (wr_req && hit_slope[i])
          slope[i] <= (slope[i] & ~lane_mask[15:0]) | (WB_DAT_I[15:0] & lane_mask[15:0]);
        if (wr_req && hit_offset[i])
          offset[i] <= (offset[i] & ~lane_mask[15:0]) | (WB_DAT_I[15:0] & lane_mask[15:0]);
      end
    end
  end
endmodule

// file: rtl/mgmt_defines.svh
// Named offsets, field positions, reset values and codes for the module management block.
// Assumes a byte-addressed register bus with 32-bit aligned words.
`ifndef MGMT_DEFINES_SVH
`define MGMT_DEFINES_SVH

`define ID_DEV_ADDR 7'h50
`define DIAG_DEV_ADDR 7'h51
`define NUM_MON 5
`define MEM_ADDR_W 9
`define PAGE_ID 1'h0
`define PAGE_DIAG 1'h1

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_LIVE 8'h0c
`define REG_MEM_ADDR 8'h10
`define REG_MEM_DATA 8'h14
`define REG_FLAGS 8'h18
`define REG_SLOPE_BASE 8'h20
`define REG_OFFSET_BASE 8'h40
`define REG_STRIDE 8'h04

`define CTRL_W 3
`define CTRL_RESET 3'h3
`define CTRL_ID_WP 0
`define CTRL_THR_WP 1
`define CTRL_SOFT_DIS 2

`define EV_W 5
`define EV_ALARM 0
`define EV_WARN 1
`define EV_FAULT 2
`define EV_LIGHT 3
`define EV_HOST_WR 4

`define SLOPE_RESET 16'h0100
`define OFFSET_RESET 16'h0000
`define CAL_LSB 8
`define CAL_MSB 23

`define THR_END 8'h60
`define LIVE_BASE 8'h60
`define LIVE_END 8'h6a
`define PROT_END 8'h80
`define ALARM_BYTE_HI 8'h70
`define ALARM_BYTE_LO 8'h71
`define WARN_BYTE_HI 8'h74
`define WARN_BYTE_LO 8'h75
`define THR_STRIDE 8
`define THR_AH 0
`define THR_AL 2
`define THR_WH 4
`define THR_WL 6

`endif

// file: rtl/mgmt_pkg.sv
// Types shared by the management block files.
// Assumes nothing beyond a SystemVerilog compiler.
package mgmt_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_WADDR = 4'h3,
    ST_WADDR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } serial_state_t;
endpackage

// file: rtl/i2c_target_core.sv
// Two-wire serial target engine: start/stop detection, address match, byte pointer.
// Assumes raw pin levels from the host; they are synchronised to clk here.
`timescale 1ns/1ps
`include "mgmt_defines.svh"

module i2c_target_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  output logic dev_sel,
  output logic [7:0] ptr,
  input wire logic [7:0] rd_data,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic start_stb
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic rw;
  logic master_ack;
  mgmt_pkg::serial_state_t state;

  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire stop_cond = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  wire byte_done = bitcnt == 4'h8;
  wire id_hit = shift[7:1] == `ID_DEV_ADDR;
  wire diag_hit = shift[7:1] == `DIAG_DEV_ADDR;
  wire [7:0] ptr_inc = ptr + 8'h01;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end
    else if (ce)
    begin
      scl_s <= {scl_s[1:0], scl_pin};
      sda_s <= {sda_s[1:0], sda_pin};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= mgmt_pkg::ST_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      dev_sel <= 1'b0;
      ptr <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      start_stb <= 1'b0;
    end
    else if (ce)
    begin
      wr_stb <= 1'b0;
      start_stb <= 1'b0;
      if (start_cond)
      begin
        state <= mgmt_pkg::ST_DEV; // [R6]
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        start_stb <= 1'b1;
      end
      else if (stop_cond)
      begin
        state <= mgmt_pkg::ST_IDLE; // [R6]
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          mgmt_pkg::ST_DEV, mgmt_pkg::ST_WADDR, mgmt_pkg::ST_WDATA:
          begin
            shift <= {shift[6:0], sda_s[1]}; // [R4]
            bitcnt <= bitcnt + 4'h1;
          end
          mgmt_pkg::ST_RACK: master_ack <= ~sda_s[1];
          default: master_ack <= master_ack;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          mgmt_pkg::ST_DEV:
          if (byte_done)
          begin
            bitcnt <= 4'h0;
            if (id_hit | diag_hit)
            begin
              state <= mgmt_pkg::ST_DEV_ACK; // [R1] [R2]
              dev_sel <= diag_hit;
              rw <= shift[0];
              sda_oe <= 1'b1;
            end
            else
              state <= mgmt_pkg::ST_IDLE;
          end
          mgmt_pkg::ST_DEV_ACK:
          if (rw)
          begin
            state <= mgmt_pkg::ST_RDATA;
            shift <= {rd_data[6:0], 1'b0};
            sda_oe <= ~rd_data[7]; // [R5]
            bitcnt <= 4'h1;
          end
          else
          begin
            state <= mgmt_pkg::ST_WADDR;
            sda_oe <= 1'b0;
          end
          mgmt_pkg::ST_WADDR:
          if (byte_done)
          begin
            state <= mgmt_pkg::ST_WADDR_ACK;
            ptr <= shift; // [R7]
            sda_oe <= 1'b1;
            bitcnt <= 4'h0;
          end
          mgmt_pkg::ST_WADDR_ACK, mgmt_pkg::ST_WDATA_ACK:
          begin
            state <= mgmt_pkg::ST_WDATA;
            sda_oe <= 1'b0;
            if (state == mgmt_pkg::ST_WDATA_ACK)
              ptr <= ptr_inc; // [R7]
          end
          mgmt_pkg::ST_WDATA:
          if (byte_done)
          begin
            state <= mgmt_pkg::ST_WDATA_ACK; // [R17]
            wr_stb <= 1'b1;
            wr_data <= shift;
            sda_oe <= 1'b1;
            bitcnt <= 4'h0;
          end
          mgmt_pkg::ST_RDATA:
          if (byte_done)
          begin
            state <= mgmt_pkg::ST_RACK;
            sda_oe <= 1'b0;
            ptr <= ptr_inc; // [R7]
          end
          else
          begin
            sda_oe <= ~shift[7]; // [R5]
            shift <= {shift[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
          mgmt_pkg::ST_RACK:
          if (master_ack)
          begin
            state <= mgmt_pkg::ST_RDATA;
            shift <= {rd_data[6:0], 1'b0};
            sda_oe <= ~rd_data[7]; // [R5]
            bitcnt <= 4'h1;
          end
          else
            state <= mgmt_pkg::ST_IDLE;
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule

// file: testbench/mgmt_props.sv
// Checker for the management block pins and register bus handshake.
// Assumes it is bound to the top module and that MCLK clocks every check.
`timescale 1ns/1ps
module mgmt_props (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_PIN_OUT,
  input wire logic SERIAL_DATA_PIN_OE,
  input wire logic PRESENCE_PIN_OUT,
  input wire logic PRESENCE_PIN_OE,
  input wire logic TX_DISABLE_PIN,
  input wire logic LASER_FAULT_IN,
  input wire logic SIGNAL_DETECT_IN,
  input wire logic LASER_ON,
  input wire logic TX_FAULT,
  input wire logic RX_LIGHT_ABSENT,
  input wire logic RX_DATA_EN
);
  default clocking cb @(posedge MCLK);
  endclocking
  // Checks pause while the clock enable freezes the block.
  default disable iff (SRST || !CE);
  presence_ground_a: assert property (PRESENCE_PIN_OE && !PRESENCE_PIN_OUT)
    else $error("presence pin not grounded");
  rx_enable_a: assert property (RX_DATA_EN == !RX_LIGHT_ABSENT)
    else $error("receive enable disagrees with light absent");
  light_found_a: assert property ($rose(SIGNAL_DETECT_IN) |-> ##[1:4] !RX_LIGHT_ABSENT)
    else $error("light absent stayed high with light present");
  laser_off_a: assert property ($rose(TX_DISABLE_PIN) |-> ##[1:4] !LASER_ON)
    else $error("laser not off after shutdown");
  laser_on_a: assert property ($rose(LASER_ON) |-> !$past(TX_DISABLE_PIN, 2))
    else $error("laser turned on while shutdown high");
  fault_out_a: assert property ($rose(LASER_FAULT_IN) |-> ##[1:4] (TX_FAULT && !LASER_ON))
    else $error("fault output missing");
  sda_edge_a: assert property ($changed(SERIAL_DATA_PIN_OE) |-> !SERIAL_CLOCK_PIN)
    else $error("data line changed with serial clock high");
  sda_drain_a: assert property (!SERIAL_DATA_PIN_OUT)
    else $error("data line driven high");
  ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered");
  ack_drop_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
endmodule

// file: testbench/serial_host_model.sv
// Behavioural host on the two-wire management bus with a 64 ns serial clock.
// Assumes the bench resolves the data wire from both pull-downs and a pull-up.
`timescale 1ns/1ps
module serial_host_model (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Data changes only while the clock is low, so the target samples it on the rise.
  task automatic clk_bit(input logic v, output logic s);
    #16 pull = !v;
    #16 scl = 1'b1;
    s = sda;
    #32 scl = 1'b0;
  endtask
  task automatic start();
    #16 pull = 1'b0;
    #16 scl = 1'b1;
    #16 pull = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic stop();
    #16 pull = 1'b1;
    #16 scl = 1'b1;
    #16 pull = 1'b0;
    #16;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule

// file: testbench/test_optical_module_mgmt_serial.sv
// Self-checking bench: register bus, pins, interrupt and serial link of the block.
// Assumes the checker and the serial host model are compiled before this file.
`timescale 1ns/1ps
`include "mgmt_defines.svh"
module test_optical_module_mgmt_serial;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o, rdat;
  logic ack, irq, sda_oe, laser_on, tx_fault, absent, rx_en, scl, pull, a;
  logic tx_dis = 1'b1;
  logic ce = 1'b1;
  logic fault = 1'b0;
  logic sdet = 1'b0;
  logic mvalid = 1'b0;
  logic [15:0] temp = 16'h0000;
  logic [7:0] rb [0:2];
  wire sda = !(pull || sda_oe);
  int err_total = 0;
  int compares = 0;
  optical_module_mgmt_serial optical_module_mgmt_serial_inst (
    .MCLK(MCLK), .SRST(SRST), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .IRQ(irq), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_IN(sda), .SERIAL_DATA_PIN_OUT(),
    .SERIAL_DATA_PIN_OE(sda_oe), .PRESENCE_PIN_OUT(), .PRESENCE_PIN_OE(),
    .TX_DISABLE_PIN(tx_dis), .LASER_FAULT_IN(fault), .SIGNAL_DETECT_IN(sdet),
    .MEAS_VALID(mvalid), .MEAS_TEMP(temp), .MEAS_VCC(16'h0), .MEAS_BIAS(16'h0),
    .MEAS_TX_POWER(16'h0), .MEAS_RX_POWER(16'h0), .LASER_ON(laser_on),
    .TX_FAULT(tx_fault), .RX_LIGHT_ABSENT(absent), .RX_DATA_EN(rx_en));
  serial_host_model serial_host_model_inst (.scl(scl), .pull(pull), .sda(sda));
  initial
    forever #2.5 MCLK = ~MCLK;
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do
    begin
      @(posedge MCLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 32'h0);
    check(rdat, exp);
  endtask
  task automatic swrite(input logic [6:0] dev, input logic [7:0] ad, input logic [7:0] d);
    serial_host_model_inst.start();
    serial_host_model_inst.send({dev, 1'b0}, a);
    serial_host_model_inst.send(ad, a);
    serial_host_model_inst.send(d, a);
    check(a, 1'b1);
    serial_host_model_inst.stop();
  endtask
  task automatic sread(input logic [6:0] dev, input logic [7:0] ad, input int n);
    serial_host_model_inst.start();
    serial_host_model_inst.send({dev, 1'b0}, a);
    serial_host_model_inst.send(ad, a);
    serial_host_model_inst.start();
    serial_host_model_inst.send({dev, 1'b1}, a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++)
      serial_host_model_inst.recv(i == n - 1, rb[i]);
    serial_host_model_inst.stop();
  endtask
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end
  initial
  begin
    tick(4);
    SRST <= 1'b0;
    rd(`REG_LIVE, 32'h5);
    rd(`REG_CTRL, 32'h3);
    tx_dis <= 1'b0;
    tick(6);
    check(laser_on, 1'b1);
    // While the clock enable is low the shutdown must not reach the laser.
    ce <= 1'b0;
    tx_dis <= 1'b1;
    tick(6);
    check(laser_on, 1'b1);
    ce <= 1'b1;
    tick(4);
    check(laser_on, 1'b0);
    tx_dis <= 1'b0;
    $display("test laser done");
    // Thresholds power up unknown; zero them so the flags settle before status is cleared.
    for (int i = 0; i < `NUM_MON * `THR_STRIDE; i++)
    begin
      wb(1'b1, `REG_MEM_ADDR, 32'h100 + i);
      wb(1'b1, `REG_MEM_DATA, 32'h0);
    end
    wb(1'b1, `REG_MASK, 32'h0);
    wb(1'b0, `REG_STATUS, 32'h0);
    fault <= 1'b1;
    tick(6);
    check({tx_fault, laser_on, irq}, 3'b100);
    wb(1'b1, `REG_MASK, 32'h4);
    tick(2);
    check(irq, 1'b1);
    rd(`REG_STATUS, 32'h4);
    tick(2);
    check(irq, 1'b0);
    fault <= 1'b0;
    sdet <= 1'b1;
    tick(6);
    check({absent, rx_en}, 2'b01);
    rd(`REG_STATUS, 32'h8);
    $display("test fault and light done");
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, `REG_MEM_ADDR, i);
      wb(1'b1, `REG_MEM_DATA, 8'h11 * (i + 1));
    end
    sread(`ID_DEV_ADDR, 8'h00, 3);
    for (int i = 0; i < 3; i++)
      check(rb[i], 8'h11 * (i + 1));
    swrite(`ID_DEV_ADDR, 8'h01, 8'h5a);
    wb(1'b1, `REG_MEM_ADDR, 32'h1);
    rd(`REG_MEM_DATA, 32'h22);
    wb(1'b1, `REG_CTRL, 32'h0);
    swrite(`ID_DEV_ADDR, 8'h02, 8'h3c);
    wb(1'b1, `REG_MEM_ADDR, 32'h2);
    rd(`REG_MEM_DATA, 32'h3c);
    rd(`REG_STATUS, 32'h10);
    $display("test id page done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, `REG_MEM_ADDR, 32'h100 + i);
      wb(1'b1, `REG_MEM_DATA, (i == 0) ? 32'h10 : 32'h0);
    end
    temp <= 16'h1234;
    mvalid <= 1'b1;
    tick(1);
    mvalid <= 1'b0;
    tick(4);
    wb(1'b0, `REG_FLAGS, 32'h0);
    check(rdat[1:0], 2'b10);
    rd(`REG_STATUS, 32'h3);
    sread(`DIAG_DEV_ADDR, 8'h60, 2);
    check({rb[0], rb[1]}, 16'h1234);
    sread(`ID_DEV_ADDR, 8'h00, 1);
    check(rb[0], 8'h11);
    serial_host_model_inst.start();
    serial_host_model_inst.send({7'h52, 1'b0}, a);
    check(a, 1'b0);
    serial_host_model_inst.stop();
    rd(8'hfc, 32'h0);
    $display("test diagnostics done");
    conclude();
  end
endmodule
bind optical_module_mgmt_serial mgmt_props mgmt_props_inst (.MCLK, .SRST, .CE, .WB_CYC_I,
  .WB_STB_I, .WB_ACK_O, .WB_DAT_O, .SERIAL_CLOCK_PIN, .SERIAL_DATA_PIN_OUT,
  .SERIAL_DATA_PIN_OE, .PRESENCE_PIN_OUT, .PRESENCE_PIN_OE, .TX_DISABLE_PIN,
  .LASER_FAULT_IN, .SIGNAL_DETECT_IN, .LASER_ON, .TX_FAULT, .RX_LIGHT_ABSENT, .RX_DATA_EN);
